// ===== tlip_chk_sva.sv
module tlip_chk
  import tlip_pkg::*;
(
  input wire logic              pclk,               // clock
  input wire logic              presetn,            // reset, low
  input wire logic              psel,               // apb select
  input wire logic              penable,            // apb enable
  input wire logic              pwrite,             // apb direction
  input wire logic [11:0]       paddr,              // apb address
  input wire logic [31:0]       pwdata,             // apb write data
  input wire logic [3:0]        pstrb,              // apb strobes
  input wire logic [31:0]       prdata,             // apb read data
  input wire logic              pready,             // apb ready
  input wire logic              pslverr,            // apb error
  input wire tlip_loop_t        loop_in,            // loop sample
  input wire logic signed [TLIP_TRQ_W-1:0] torque_out, // clamped torque
  input wire logic              in_position_output  // in-position level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access and write qualifiers
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  AST_RDY: assert property (acc |-> pready) else $error("pready low in access phase");
  AST_IDLE: assert property (!acc |-> prdata == 32'h0 && !pslverr) else $error("bus outputs not idle");
  AST_STRB: assert property (wr && pstrb != 4'hf |-> pslverr) else $error("partial write accepted");
  AST_UNMAP: assert property (acc && paddr > TLIP_OFF_TORQUE |-> pslverr) else $error("unmapped access accepted");
  AST_RO: assert property (wr && paddr == TLIP_OFF_SYSMAX |-> pslverr) else $error("sysmax written");
  AST_LIM: assert property (wr && (paddr == TLIP_OFF_TLIM1 || paddr == TLIP_OFF_TLIM2) && pwdata > 32'h12c
    |-> pslverr) else $error("limit above sysmax accepted");
  AST_WIN: assert property (wr && paddr == TLIP_OFF_WINDOW && pwdata > 32'h7fff |-> pslverr)
    else $error("window above range accepted");
  AST_TRQ: assert property (!loop_in.valid |=> $stable(torque_out)) else $error("torque moved without update");
  AST_POS: assert property (!loop_in.valid |=> $stable(in_position_output))
    else $error("in-position moved without update");
  AST_ZERO: assert property (loop_in.valid && loop_in.torque == 16'sh0 |=> torque_out == 16'sh0)
    else $error("zero torque not passed");
endmodule // tlip_chk

bind tlip_top tlip_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .loop_in, .torque_out, .in_position_output);

// ===== tlip_clamp.sv
module tlip_clamp
  import tlip_pkg::*;
(
  input  wire logic                         pclk,      // bus clock
  input  wire logic                         presetn,   // async reset, low
  input  wire logic                         upd,       // control update strobe
  input  wire logic signed [TLIP_TRQ_W-1:0] cmd,       // torque command
  input  wire logic        [TLIP_PCT_W-1:0] pct,       // active limit percent
  input  wire logic        [TLIP_TRQ_W-1:0] rated,     // rated torque units
  output logic signed      [TLIP_TRQ_W-1:0] out_q,     // clamped torque
  output logic                              clip_q     // pulse: clamp acted
);
  localparam int PW = TLIP_PCT_W + TLIP_TRQ_W;

  logic [PW-1:0]         prod;
  logic [PW-1:0]         lim_full;
  logic [TLIP_TRQ_W:0]   lim;
  logic [TLIP_TRQ_W:0]   mag;
  logic                  neg;
  logic                  over;
  logic signed [TLIP_TRQ_W-1:0] sat;

  // limit = pct * rated / 100, same magnitude both directions
  assign prod     = PW'(pct) * PW'(rated);
  assign lim_full = prod / PW'(TLIP_HUNDRED);
  assign lim      = (lim_full > PW'({1'b0, {TLIP_TRQ_W{1'b1}}} >> 1)) ?
                    (TLIP_TRQ_W+1)'({1'b0, {TLIP_TRQ_W{1'b1}}} >> 1) :
                    lim_full[TLIP_TRQ_W:0];
  assign neg      = cmd[TLIP_TRQ_W-1];
  assign mag      = neg ? (TLIP_TRQ_W+1)'(-$signed({cmd[TLIP_TRQ_W-1], cmd})) :
                          (TLIP_TRQ_W+1)'(cmd);
  assign over     = mag > lim;
  assign sat      = neg ? TLIP_TRQ_W'(-$signed({1'b0, lim})) : TLIP_TRQ_W'(lim);

  // out_q updates only on control strobe; clip_q is rewritten every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q  <= '0;
      clip_q <= 1'b0;
    end else begin
      clip_q <= upd & over;
      if (upd) begin
        out_q <= over ? sat : cmd;
      end
    end
  end
endmodule // tlip_clamp

// ===== tlip_host.sv
module tlip_host
  import tlip_pkg::*;
(
  input  wire logic       pclk,               // clock
  input  wire logic       presetn,            // reset, low
  input  wire logic       in_position_output, // watched level
  output logic      [7:0] rises_q             // completions seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen_q;
  // host only counts completions; window sizing is left to the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
      rises_q <= 8'h0;
    end else begin
      seen_q <= in_position_output;
      rises_q <= rises_q + 8'(in_position_output & ~seen_q);
    end
  end
endmodule // tlip_host

// ===== tlip_pkg.sv
package tlip_pkg;
  // register byte offsets
  localparam logic [11:0] TLIP_OFF_TLIM1   = 12'h000;
  localparam logic [11:0] TLIP_OFF_TLIM2   = 12'h004;
  localparam logic [11:0] TLIP_OFF_SELECT  = 12'h008;
  localparam logic [11:0] TLIP_OFF_WINDOW  = 12'h00c;
  localparam logic [11:0] TLIP_OFF_MODE    = 12'h010;
  localparam logic [11:0] TLIP_OFF_SYSMAX  = 12'h014;
  localparam logic [11:0] TLIP_OFF_RATED   = 12'h018;
  localparam logic [11:0] TLIP_OFF_STATUS  = 12'h01c;
  localparam logic [11:0] TLIP_OFF_IRQ_ST  = 12'h020;
  localparam logic [11:0] TLIP_OFF_IRQ_MSK = 12'h024;
  localparam logic [11:0] TLIP_OFF_TORQUE  = 12'h028;

  // field widths and resets
  localparam int          TLIP_PCT_W       = 10;
  localparam int          TLIP_WIN_W       = 15;
  localparam int          TLIP_TRQ_W       = 16;
  localparam int          TLIP_DEV_W       = 24;
  localparam logic [9:0]  TLIP_PCT_MAX     = 10'h1f4;   // 500 %
  localparam logic [9:0]  TLIP_PCT_RST     = 10'h1f4;
  localparam logic [9:0]  TLIP_SYSMAX_RST  = 10'h12c;   // 300 %, about three times rated
  localparam logic [14:0] TLIP_WIN_RST     = 15'h0083;  // 131 pulses
  localparam logic [15:0] TLIP_RATED_RST   = 16'h0400;
  localparam logic [6:0]  TLIP_HUNDRED     = 7'h64;
  localparam int          TLIP_IRQ_W       = 3;
  localparam int          TLIP_IRQ_INPOS   = 0;
  localparam int          TLIP_IRQ_CLAMP   = 1;
  localparam int          TLIP_IRQ_REJECT  = 2;

  typedef enum logic [1:0] {
    TLIP_MODE_DEV,
    TLIP_MODE_NOCMD,
    TLIP_MODE_ZSPD,
    TLIP_MODE_HOLD
  } tlip_mode_t;

  typedef enum logic {
    TLIP_FB_ENCODER,
    TLIP_FB_SCALE
  } tlip_fb_t;

  // one control-loop sample
  typedef struct packed {
    logic                         valid;
    logic signed [TLIP_TRQ_W-1:0] torque;
    logic signed [TLIP_DEV_W-1:0] dev_enc;
    logic signed [TLIP_DEV_W-1:0] dev_scale;
    logic                         cmd_active;
    logic                         zero_speed;
    logic                         full_closed;
    logic                         limit_sel_in;
  } tlip_loop_t;
endpackage

// ===== tlip_top.sv
// The address map and the APB interface to the registers were chosen for this implementation.
module tlip_top
  import tlip_pkg::*;
#(
  parameter logic [9:0] LIM_DEFAULT = TLIP_PCT_RST       // motor-pairing default
) (
  input  wire logic                         pclk,               // bus clock 25 MHz
  input  wire logic                         presetn,            // async reset, low
  input  wire logic                         psel,               // apb select
  input  wire logic                         penable,            // apb enable
  input  wire logic                         pwrite,             // apb direction
  input  wire logic [11:0]                  paddr,              // apb byte address
  input  wire logic [31:0]                  pwdata,             // apb write data
  input  wire logic [3:0]                   pstrb,              // apb byte strobes
  output logic      [31:0]                  prdata,             // apb read data
  output logic                              pready,             // apb ready
  output logic                              pslverr,            // apb error
  input  wire tlip_loop_t                   loop_in,            // control loop sample
  output logic signed [TLIP_TRQ_W-1:0]      torque_out,         // clamped torque
  output logic                              in_position_output, // in-position level
  output logic                              irq                 // level interrupt
);
  logic [TLIP_PCT_W-1:0]  first_torque_limit_q;
  logic [TLIP_PCT_W-1:0]  second_torque_limit_q;
  logic                   torque_limit_select_q;
  logic [TLIP_WIN_W-1:0]  in_position_window_q;
  tlip_mode_t             in_position_output_mode_q;
  logic [TLIP_PCT_W-1:0]  sysmax_q;
  logic [TLIP_TRQ_W-1:0]  rated_q;
  logic [TLIP_IRQ_W-1:0]  irq_st_q;
  logic [TLIP_IRQ_W-1:0]  irq_msk_q;
  logic                   inpos_q;
  logic                   hold_q;
  logic                   cmd_seen_q;

  // apb decode
  wire        wr_en   = psel & penable & pwrite;
  wire        rd_en   = psel & penable & ~pwrite;
  wire        sel_l1  = (paddr == TLIP_OFF_TLIM1);
  wire        sel_l2  = (paddr == TLIP_OFF_TLIM2);
  wire        sel_sel = (paddr == TLIP_OFF_SELECT);
  wire        sel_win = (paddr == TLIP_OFF_WINDOW);
  wire        sel_md  = (paddr == TLIP_OFF_MODE);
  wire        sel_sm  = (paddr == TLIP_OFF_SYSMAX);
  wire        sel_rt  = (paddr == TLIP_OFF_RATED);
  wire        sel_st  = (paddr == TLIP_OFF_STATUS);
  wire        sel_is  = (paddr == TLIP_OFF_IRQ_ST);
  wire        sel_im  = (paddr == TLIP_OFF_IRQ_MSK);
  wire        sel_tq  = (paddr == TLIP_OFF_TORQUE);
  wire        mapped  = sel_l1 | sel_l2 | sel_sel | sel_win | sel_md | sel_sm |
                        sel_rt | sel_st | sel_is | sel_im | sel_tq;
  wire        full_wr = &pstrb;

  // limit value check; narrow strobes and out-of-range writes are refused
  function automatic logic lim_ok(input logic [31:0] v, input logic [TLIP_PCT_W-1:0] mx);
    lim_ok = (v <= 32'(TLIP_PCT_MAX)) && (v[TLIP_PCT_W-1:0] <= mx);
  endfunction

  wire        l_ok     = lim_ok(pwdata, sysmax_q);
  wire        lim_wr   = wr_en & (sel_l1 | sel_l2);
  wire        lim_bad  = lim_wr & (~l_ok | ~full_wr);
  wire        win_bad  = wr_en & sel_win & (pwdata > 32'({TLIP_WIN_W{1'b1}}));
  wire        ro_wr    = wr_en & (sel_st | sel_tq | sel_sm);
  wire        wr_bad   = wr_en & (~mapped | lim_bad | win_bad | ro_wr | ~full_wr);
  wire        wr_good  = wr_en & ~wr_bad;

  assign pready  = 1'b1;
  assign pslverr = (wr_bad) | (rd_en & ~mapped);

  // limit settings; system max is fixed at reset, not writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_torque_limit_q  <= LIM_DEFAULT;
      second_torque_limit_q <= LIM_DEFAULT;
      sysmax_q              <= TLIP_SYSMAX_RST;
    end else begin
      if (wr_good & sel_l1) first_torque_limit_q  <= pwdata[TLIP_PCT_W-1:0];
      if (wr_good & sel_l2) second_torque_limit_q <= pwdata[TLIP_PCT_W-1:0];
    end
  end

  // other configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_limit_select_q     <= 1'b0;
      in_position_window_q      <= TLIP_WIN_RST;
      in_position_output_mode_q <= TLIP_MODE_DEV;
      rated_q                   <= TLIP_RATED_RST;
      irq_msk_q                 <= '0;
    end else if (wr_good) begin
      if (sel_sel) torque_limit_select_q     <= pwdata[0];
      if (sel_win) in_position_window_q      <= pwdata[TLIP_WIN_W-1:0];
      if (sel_md)  in_position_output_mode_q <= tlip_mode_t'(pwdata[1:0]);
      if (sel_rt)  rated_q                   <= pwdata[TLIP_TRQ_W-1:0];
      if (sel_im)  irq_msk_q                 <= pwdata[TLIP_IRQ_W-1:0];
    end
  end

  // active limit: second limit only when select register is set and external select input is high
  wire              sel2    = torque_limit_select_q ? loop_in.limit_sel_in : 1'b0;
  wire [TLIP_PCT_W-1:0] act_pct = sel2 ? second_torque_limit_q : first_torque_limit_q;
  // sysmax caps both so untouched limits still land near three times rated
  wire [TLIP_PCT_W-1:0] eff_pct = (act_pct > sysmax_q) ? sysmax_q : act_pct;
  logic             clip;

  tlip_clamp u_clamp (
    .pclk    (pclk),
    .presetn (presetn),
    .upd     (loop_in.valid),
    .cmd     (loop_in.torque),
    .pct     (eff_pct),
    .rated   (rated_q),
    .out_q   (torque_out),
    .clip_q  (clip)
  );

  // deviation source, raw counts at encoder or scale resolution
  wire signed [TLIP_DEV_W-1:0] dev = loop_in.full_closed ? loop_in.dev_scale
                                                         : loop_in.dev_enc;
  wire [TLIP_DEV_W-1:0] dev_mag = dev[TLIP_DEV_W-1] ? TLIP_DEV_W'(-dev) : dev;
  // window only gates the flag; clamp and loop never see it
  wire in_win  = dev_mag <= TLIP_DEV_W'(in_position_window_q);
  wire no_cmd  = ~loop_in.cmd_active;

  // mode qualified in-position condition
  logic cond;
  always_comb begin
    cond = 1'b0;
    case (in_position_output_mode_q)
      TLIP_MODE_DEV:   cond = in_win & (no_cmd | ~cmd_seen_q);
      TLIP_MODE_NOCMD: cond = in_win & no_cmd;
      TLIP_MODE_ZSPD:  cond = in_win & no_cmd & loop_in.zero_speed;
      TLIP_MODE_HOLD:  cond = (in_win & no_cmd) | (hold_q & no_cmd);
      default:         cond = 1'b0;
    endcase
  end

  // in-position state, evaluated each control update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inpos_q    <= 1'b0;
      hold_q     <= 1'b0;
      cmd_seen_q <= 1'b0;
    end else if (loop_in.valid) begin
      inpos_q    <= cond;
      hold_q     <= cond & no_cmd;
      cmd_seen_q <= loop_in.cmd_active;
    end
  end
  assign in_position_output = inpos_q;

  // sticky events; a set in the clearing cycle wins
  wire inpos_rise = loop_in.valid & cond & ~inpos_q;
  wire [TLIP_IRQ_W-1:0] ev = {lim_bad, clip, inpos_rise};
  wire [TLIP_IRQ_W-1:0] clr = (wr_good & sel_is) ? pwdata[TLIP_IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_st_q <= '0;
    else          irq_st_q <= (irq_st_q & ~clr) | ev;
  end
  assign irq = |(irq_st_q & irq_msk_q);

  // read mux
  assign prdata = !rd_en   ? 32'h0000_0000 :
                  sel_l1   ? 32'(first_torque_limit_q) :
                  sel_l2   ? 32'(second_torque_limit_q) :
                  sel_sel  ? 32'(torque_limit_select_q) :
                  sel_win  ? 32'(in_position_window_q) :
                  sel_md   ? 32'(in_position_output_mode_q) :
                  sel_sm   ? 32'(sysmax_q) :
                  sel_rt   ? 32'(rated_q) :
                  sel_st   ? 32'({sel2, inpos_q}) :
                  sel_is   ? 32'(irq_st_q) :
                  sel_im   ? 32'(irq_msk_q) :
                  sel_tq   ? 32'($unsigned(torque_out)) :
                             32'h0000_0000;
endmodule // tlip_top

// ===== torque_limit_and_in_position_tb.sv
module torque_limit_and_in_position_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tlip_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, inpos, irq, er, a;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [7:0]  rises;
  logic signed [TLIP_TRQ_W-1:0] tq;
  tlip_loop_t  lp = '0;
  int          failures = 0, checks = 0;
  // 25 MHz bus clock
  always #20 pclk = ~pclk;
  tlip_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .loop_in(lp), .torque_out(tq), .in_position_output(inpos), .irq);
  tlip_host host (.pclk, .presetn, .in_position_output(inpos), .rises_q(rises));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; waits on pready, never on a fixed count
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic ee);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", er, ee);
  endtask
  task rdc(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0, 1'b0);
    chk("prdata", rd, e);
  endtask
  // one loop update; outputs settle the cycle after valid
  task samp(input logic signed [15:0] t, input logic signed [23:0] de, ds, input logic [3:0] f);
    @(posedge pclk);
    lp <= {1'b1, t, de, ds, f};
    @(posedge pclk);
    lp.valid <= 1'b0;
    #1;
  endtask
  task pos(input logic [1:0] m, input logic signed [23:0] de, ds, input logic [3:0] f, input logic e);
    apb(1'b1, TLIP_OFF_MODE, {30'h0, m}, 1'b0);
    samp(16'sh0, de, ds, f);
    chk("in_position_output", inpos, e);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog, far beyond the couple of hundred cycles the tests take
  initial begin
    #(40 * 20000);
    failures++;
    print_verdict;
  end
  // main sequence, flags are {cmd_active, zero_speed, full_closed, limit_sel_in}
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(TLIP_OFF_TLIM1, 32'h1f4);
    rdc(TLIP_OFF_TLIM2, 32'h1f4);
    rdc(TLIP_OFF_WINDOW, 32'h83);
    rdc(TLIP_OFF_SYSMAX, 32'h12c);
    rdc(TLIP_OFF_MODE, 32'h0);
    apb(1'b1, TLIP_OFF_TLIM1, 32'h1f5, 1'b1);
    apb(1'b1, TLIP_OFF_TLIM2, 32'h12d, 1'b1);
    apb(1'b1, TLIP_OFF_SYSMAX, 32'h0, 1'b1);
    rdc(TLIP_OFF_TLIM1, 32'h1f4);
    rdc(TLIP_OFF_IRQ_ST, 32'h4);
    apb(1'b1, TLIP_OFF_IRQ_MSK, 32'h7, 1'b0);
    #1 a = irq;
    apb(1'b1, TLIP_OFF_IRQ_MSK, 32'h0, 1'b0);
    #1 chk("irq mask effect", {31'h0, irq ^ a}, 32'h1);
    apb(1'b1, TLIP_OFF_IRQ_ST, 32'h7, 1'b0);
    // unmask again so a failed clear would show on irq
    apb(1'b1, TLIP_OFF_IRQ_MSK, 32'h7, 1'b0);
    #1 chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, TLIP_OFF_RATED, 32'h64, 1'b0);
    apb(1'b1, TLIP_OFF_TLIM1, 32'h96, 1'b0);
    samp(16'sh3e8, 24'sh0, 24'sh0, 4'h0);
    chk("torque_out", tq, 32'sh96);
    samp(-16'sh3e8, 24'sh0, 24'sh0, 4'h0);
    chk("torque_out", tq, -32'sh96);
    chk("irq", {31'h0, irq}, 32'h1);
    samp(16'sh64, 24'sh0, 24'sh0, 4'h0);
    chk("torque_out", tq, 32'sh64);
    rdc(TLIP_OFF_TORQUE, 32'h64);
    apb(1'b1, TLIP_OFF_TLIM2, 32'h32, 1'b0);
    apb(1'b1, TLIP_OFF_SELECT, 32'h1, 1'b0);
    samp(16'sh3e8, 24'sh0, 24'sh0, 4'h1);
    chk("torque_out", tq, 32'sh32);
    samp(16'sh3e8, 24'sh0, 24'sh0, 4'h0);
    chk("torque_out", tq, 32'sh96);
    rdc(TLIP_OFF_IRQ_ST, 32'h3);
    apb(1'b1, TLIP_OFF_WINDOW, 32'h8000, 1'b1);
    apb(1'b1, TLIP_OFF_WINDOW, 32'ha, 1'b0);
    pos(2'h1, 24'sh5, 24'sh0, 4'h8, 1'b0);
    pos(2'h1, 24'sha, 24'sh0, 4'h0, 1'b1);
    pos(2'h1, -24'shb, 24'sh0, 4'h0, 1'b0);
    pos(2'h1, 24'sh14, 24'sh3, 4'h2, 1'b1);
    pos(2'h2, 24'sh0, 24'sh0, 4'h0, 1'b0);
    pos(2'h2, 24'sh0, 24'sh0, 4'h4, 1'b1);
    pos(2'h3, 24'sh0, 24'sh0, 4'h0, 1'b1);
    pos(2'h3, 24'sh64, 24'sh0, 4'h0, 1'b1);
    pos(2'h3, 24'sh0, 24'sh0, 4'h8, 1'b0);
    pos(2'h0, -24'sha, 24'sh0, 4'h0, 1'b1);
    pos(2'h0, 24'shb, 24'sh0, 4'h0, 1'b0);
    chk("rises", {24'h0, rises}, 32'h5);
    pos(2'h0, 24'sh0, 24'sh0, 4'h8, 1'b1);
    pos(2'h0, 24'sh0, 24'sh0, 4'h8, 1'b0);
    apb(1'b0, 12'h030, 32'h0, 1'b1);
    pstrb <= 4'h3;
    apb(1'b1, TLIP_OFF_TLIM1, 32'h64, 1'b1);
    pstrb <= 4'hf;
    rdc(TLIP_OFF_TLIM1, 32'h96);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(TLIP_OFF_TLIM1, 32'h1f4);
    chk("torque_out", tq, 32'h0);
    print_verdict;
  end
endmodule // torque_limit_and_in_position_tb
